// [verilog/hd_fmt_source.sv]
// Source end: line timing, quantization and word multiplex
`timescale 1ns/10ps
`default_nettype none
module hd_fmt_source
    import hd_fmt_pkg::*;
(
    // Clock and reset (luma sample clock)
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Configuration
    input wire logic ten_bit_i,
    input wire logic rgb_mode_i,
    input wire family_t family_i,
    // Normalized samples (Q16)
    input wire logic [16:0] y_g_i,
    input wire logic [16:0] cb_b_i,
    input wire logic [16:0] cr_r_i,
    // Request of the next active sample
    output logic sample_req_o,
    // Link
    hd_fmt_if.source link
);
    typedef enum logic [1:0] {ST_BLANK, ST_ACTIVE} phase_t;

    typedef struct packed {
        phase_t phase;
        logic [CNT_W-1:0] pos;
        logic [LINE_W-1:0] line;
        logic odd;
        logic [9:0] cr_hold;
        logic [29:0] data;
        logic valid;
        logic active;
        logic line_start;
    } src_state_t;

    src_state_t s_q;
    src_state_t s_d;
    logic [9:0] q_y;
    logic [9:0] q_cb;
    logic [9:0] q_cr;
    logic act_dly;
    logic in_act;

    // ----------------------------------------------------------------
    // Quantizers; one cycle latency matched by act_dly
    // ----------------------------------------------------------------
    hd_quantizer u_q_y (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .norm_i(y_g_i),
        .chroma_i(1'b0), .ten_bit_i(ten_bit_i), .code_o(q_y));
    hd_quantizer u_q_cb (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .norm_i(cb_b_i),
        .chroma_i(!rgb_mode_i), .ten_bit_i(ten_bit_i), .code_o(q_cb));
    hd_quantizer u_q_cr (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .norm_i(cr_r_i),
        .chroma_i(!rgb_mode_i), .ten_bit_i(ten_bit_i), .code_o(q_cr));

    // ----------------------------------------------------------------
    // Line timing
    // ----------------------------------------------------------------
    // pos 0 is the sync reference; active starts SYNC_TO_ACTIVE later
    assign in_act = (s_q.pos >= CNT_W'(SYNC_TO_ACTIVE))
                  && (s_q.pos < CNT_W'(SYNC_TO_ACTIVE + ACTIVE_Y))
                  && (s_q.line < LINE_W'(ACTIVE_LINES));
    assign sample_req_o = in_act;

    always_comb
    begin
        s_d = s_q;
        s_d.line_start = 1'b0;
        if (s_q.pos == line_total(family_i) - CNT_W'(1))
        begin
            s_d.pos = '0;
            s_d.line_start = 1'b1;
            s_d.line = (s_q.line == LINE_W'(ACTIVE_LINES)) ? '0 : s_q.line + LINE_W'(1);
        end
        else
        begin
            s_d.pos = s_q.pos + CNT_W'(1);
        end
        s_d.phase = in_act ? ST_ACTIVE : ST_BLANK;
        // One blank line past the picture takes the spare line count, then the line count wraps to 0
        s_d.valid = 1'b1;
        s_d.active = act_dly;
        if (!act_dly)
        begin
            s_d.odd = 1'b0;
            s_d.data = {10'd0, width_fix(ACHROMA_CODE, ten_bit_i),
                        width_fix(BLACK_CODE, ten_bit_i)};
        end
        else if (rgb_mode_i)
        begin
            s_d.data = {q_cr, q_cb, q_y};
        end
        else
        begin
            // Chroma taken on first of each pair only; Cr held for next word
            s_d.odd = !s_q.odd;
            if (!s_q.odd)
            begin
                s_d.cr_hold = q_cr;
                s_d.data = {10'd0, q_cb, q_y};
            end
            else
            begin
                s_d.data = {10'd0, s_q.cr_hold, q_y};
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            s_q <= '0;
            act_dly <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
            act_dly <= in_act;
        end
    end

    // Link only driven here, no input from the sink
    assign link.data = s_q.data;
    assign link.valid = s_q.valid;
    assign link.active = s_q.active;
    assign link.rgb = rgb_mode_i;
    assign link.ten_bit = ten_bit_i;
    assign link.line_start = s_q.line_start;
endmodule : hd_fmt_source
`default_nettype wire

// [verilog/hd_fmt_pkg.sv]
// Constants, types and code-level helpers for the HD component sample formatter
// Function
// - Luma/RGB code: E*219D + 16D + 0.5, truncated
// - Chroma code: E*224D + 128D + 0.5, truncated
// - Scale D is 1 for 8-bit, 4 for 10-bit
// - One source, one destination, no return path
// - 20-bit words pair Cb/Cr alternately with Y
// - Chroma co-sited with odd luma, first with first
// - Codes 0.00-0.75 and 255.00-255.75 never video
// - RGB carried as 30-bit words
// - Two LSBs of 10-bit code are fractional
// - 8-bit word into 10-bit path: append 00
// - 8-bit implementation uses eight MSBs only
// - Black 16, peak 235, achromatic 128, 16/240
// - 1920 active luma, 960 active per chroma
// - 1080 active lines per picture
// - Total line 2200, 2640 or 2750 samples
// - First active sample 192 clocks after sync
// - Chroma at half luma rate
// - Destination tolerates out-of-nominal legal levels
// - Timing code: three preamble words, then FVH; the source sends no timing code, only the line_start flag
package hd_fmt_pkg;

    // ----------------------------------------------------------------
    // Coding constants (gains and offsets at 8-bit scale times D, codes at 10-bit scale)
    // ----------------------------------------------------------------
    localparam int unsigned FRAC_BITS = 16;
    localparam logic [9:0] Y_GAIN = 10'd219;
    localparam logic [9:0] Y_OFFS = 10'd16;
    localparam logic [9:0] C_GAIN = 10'd224;
    localparam logic [9:0] C_OFFS = 10'd128;
    localparam logic [2:0] D_8BIT = 3'd1;
    localparam logic [2:0] D_10BIT = 3'd4;
    localparam logic [9:0] CODE_MIN = 10'h004;
    localparam logic [9:0] CODE_MAX = 10'h3fb;
    localparam logic [9:0] BLACK_CODE = 10'h040;
    localparam logic [9:0] ACHROMA_CODE = 10'h200;
    localparam logic [9:0] PREAMBLE_HI = 10'h3ff;
    localparam logic [9:0] PREAMBLE_LO = 10'h000;

    // ----------------------------------------------------------------
    // Line and picture timing
    // ----------------------------------------------------------------
    localparam int unsigned ACTIVE_Y = 1920;
    localparam int unsigned ACTIVE_C = 960;
    localparam int unsigned ACTIVE_LINES = 1080;
    localparam int unsigned TOTAL_60 = 2200;
    localparam int unsigned TOTAL_50 = 2640;
    localparam int unsigned TOTAL_24 = 2750;
    localparam int unsigned SYNC_TO_ACTIVE = 192;
    localparam int unsigned MARKER_LEN = 4;
    localparam int unsigned CNT_W = 12;
    localparam int unsigned LINE_W = 11;

    typedef enum logic [1:0] {FAM_60, FAM_50, FAM_24} family_t;
    typedef enum logic {FMT_YC, FMT_RGB} fmt_t;

    // Total samples per line for a family
    function automatic logic [CNT_W-1:0] line_total(input family_t fam);
        case (fam)
            FAM_50: line_total = CNT_W'(TOTAL_50);
            FAM_24: line_total = CNT_W'(TOTAL_24);
            default: line_total = CNT_W'(TOTAL_60);
        endcase
    endfunction : line_total

    // Keep 8-bit mode to the eight MSBs with zero LSBs
    function automatic logic [9:0] width_fix(input logic [9:0] c, input logic ten_bit);
        width_fix = ten_bit ? c : {c[9:2], 2'b00};
    endfunction : width_fix

endpackage : hd_fmt_pkg

// [verilog/hd_fmt_if.sv]
// One-way parallel link between formatter source and destination
`timescale 1ns/10ps
`default_nettype none
interface hd_fmt_if;
    import hd_fmt_pkg::*;
    logic [29:0] data;
    logic valid;
    logic active;
    logic rgb;
    logic ten_bit;
    logic line_start;

    // Only the source drives; nothing flows back
    modport source (output data, valid, active, rgb, ten_bit, line_start);
    modport sink (input data, valid, active, rgb, ten_bit, line_start);
endinterface : hd_fmt_if
`default_nettype wire

// [verilog/hd_quantizer.sv]
// Fixed-point quantizer for one component into a legal 10-bit code
`timescale 1ns/10ps
`default_nettype none
module hd_quantizer
    import hd_fmt_pkg::*;
(
    // Clock
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Sample
    input wire logic [16:0] norm_i,
    input wire logic chroma_i,
    input wire logic ten_bit_i,
    // Code
    output logic [9:0] code_o
);
    typedef struct packed {
        logic [9:0] code;
    } q_state_t;

    q_state_t s_q;
    q_state_t s_d;
    logic signed [17:0] e;
    logic signed [31:0] prod;
    logic signed [31:0] lvl;
    logic [2:0] dsc;

    always_comb
    begin
        s_d = s_q;
        e = chroma_i ? {{1{norm_i[16]}}, norm_i} : {1'b0, norm_i};
        dsc = ten_bit_i ? D_10BIT : D_8BIT;
        // norm is Q16: luma 0..1 unsigned, chroma -0.5..0.5 signed
        prod = e * (chroma_i ? $signed({22'd0, C_GAIN}) : $signed({22'd0, Y_GAIN}))
               * $signed({29'd0, dsc});
        lvl = (prod + ((chroma_i ? $signed({22'd0, C_OFFS}) : $signed({22'd0, Y_OFFS}))
               * $signed({29'd0, dsc}) <<< FRAC_BITS) + (32'sd1 <<< (FRAC_BITS - 1)))
               >>> FRAC_BITS;
        if (!ten_bit_i)
        begin
            lvl = lvl <<< 2;
        end
        // Saturate, never wrap into reserved codes
        if (lvl < $signed({22'd0, CODE_MIN}))
        begin
            s_d.code = width_fix(CODE_MIN, ten_bit_i);
        end
        else if (lvl > $signed({22'd0, CODE_MAX}))
        begin
            s_d.code = width_fix(CODE_MAX, ten_bit_i);
        end
        else
        begin
            s_d.code = width_fix(lvl[9:0], ten_bit_i);
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            s_q <= '{code: BLACK_CODE};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign code_o = s_q.code;
endmodule : hd_quantizer
`default_nettype wire

// [verilog/hd_fmt_sink.sv]
// Destination end: demultiplexes words back into components
`timescale 1ns/10ps
`default_nettype none
module hd_fmt_sink
    import hd_fmt_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Link
    hd_fmt_if.sink link,
    // Recovered samples
    output logic [9:0] y_g_o,
    output logic [9:0] cb_b_o,
    output logic [9:0] cr_r_o,
    output logic sample_vld_o,
    output logic chroma_vld_o,
    output logic [CNT_W-1:0] active_cnt_o
);
    typedef struct packed {
        logic [9:0] y;
        logic [9:0] cb;
        logic [9:0] cr;
        logic vld;
        logic cvld;
        logic odd;
        logic [CNT_W-1:0] cnt;
    } snk_state_t;

    snk_state_t s_q;
    snk_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.vld = 1'b0;
        s_d.cvld = 1'b0;
        if (link.line_start)
        begin
            s_d.cnt = '0;
            s_d.odd = 1'b0;
        end
        if (link.valid && link.active)
        begin
            // Any legal code accepted, nominal range not enforced
            s_d.y = width_fix(link.data[9:0], link.ten_bit);
            s_d.vld = 1'b1;
            s_d.cnt = s_q.cnt + CNT_W'(1);
            if (link.rgb)
            begin
                s_d.cb = link.data[19:10];
                s_d.cr = link.data[29:20];
                s_d.cvld = 1'b1;
            end
            else if (!s_q.odd)
            begin
                s_d.cb = link.data[19:10];
                s_d.odd = 1'b1;
            end
            else
            begin
                s_d.cr = link.data[19:10];
                s_d.odd = 1'b0;
                s_d.cvld = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign y_g_o = s_q.y;
    assign cb_b_o = s_q.cb;
    assign cr_r_o = s_q.cr;
    assign sample_vld_o = s_q.vld;
    assign chroma_vld_o = s_q.cvld;
    assign active_cnt_o = s_q.cnt;
endmodule : hd_fmt_sink
`default_nettype wire

// [dv/hd_fmt_monitor.sv]
// Assertion monitor for the formatter link
`timescale 1ns/10ps
`default_nettype none
module hd_fmt_monitor
    import hd_fmt_pkg::*;
(
    // Link signals
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [29:0] data,
    input wire logic valid,
    input wire logic active,
    input wire logic rgb,
    input wire logic ten_bit,
    input wire logic line_start
);
    // ----------------------------------------------------------------
    // Helper counters and checks
    // ----------------------------------------------------------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    logic [11:0] cnt_q;
    logic [10:0] run_q;
    logic seen_q;
    // The first line after reset has no predecessor, so seen_q gates the period check
    always_ff @(posedge sys_clk_i)
    begin
        cnt_q <= (srst_i || line_start) ? 12'h001 : cnt_q + 12'h001;
        run_q <= (srst_i || !active) ? 11'h000 : run_q + 11'h001;
        seen_q <= !srst_i && (seen_q || line_start);
    end
    property p_legal_y;
        active |-> data[9:0] >= CODE_MIN && data[9:0] <= CODE_MAX;
    endproperty
    a_legal_y: assert property (p_legal_y) else $error("luma code reserved");
    property p_legal_c;
        active |-> data[19:10] >= CODE_MIN && data[19:10] <= CODE_MAX;
    endproperty
    a_legal_c: assert property (p_legal_c) else $error("middle code reserved");
    property p_rgb_hi;
        active && rgb |-> data[29:20] >= CODE_MIN && data[29:20] <= CODE_MAX;
    endproperty
    a_rgb_hi: assert property (p_rgb_hi) else $error("red code reserved");
    property p_yc_hi;
        !rgb |-> data[29:20] == 10'h000;
    endproperty
    a_yc_hi: assert property (p_yc_hi) else $error("upper field not clear");
    property p_eight;
        !ten_bit && active |-> data[1:0] == 2'b00 && data[11:10] == 2'b00;
    endproperty
    a_eight: assert property (p_eight) else $error("fraction bits set");
    property p_blank;
        valid && !active && !rgb |-> data[19:0] == {ACHROMA_CODE, BLACK_CODE};
    endproperty
    a_blank: assert property (p_blank) else $error("blanking level wrong");
    property p_valid;
        !$past(srst_i) |-> valid;
    endproperty
    a_valid: assert property (p_valid) else $error("word missing");
    property p_period;
        line_start && seen_q |-> cnt_q == 12'd2200 || cnt_q == 12'd2640 || cnt_q == 12'd2750;
    endproperty
    a_period: assert property (p_period) else $error("line length wrong");
    property p_run;
        $fell(active) |-> run_q == 11'd1920;
    endproperty
    a_run: assert property (p_run) else $error("active run wrong");
    c_rgb: cover property (active && rgb);
    c_eight: cover property (active && !ten_bit);
    c_line: cover property (line_start && seen_q);
endmodule : hd_fmt_monitor
`default_nettype wire

// [dv/hd_component_sample_formatter_tb.sv]
// Self-checking bench for the source and sink pair
`timescale 1ns/10ps
`default_nettype none
module hd_component_sample_formatter_tb;
    import hd_fmt_pkg::*;
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin mismatches++; $display("unexpected %s exp %h got %h", n, e, s); end end
    // ----------------------------------------------------------------
    // Stimulus and wiring
    // ----------------------------------------------------------------
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ten_bit_i = 1'b1;
    logic rgb_mode_i = 1'b0;
    family_t family_i = FAM_60;
    logic [16:0] y_g_i = '0;
    logic [16:0] cb_b_i = '0;
    logic [16:0] cr_r_i = '0;
    logic sample_req_o, sample_vld_o, chroma_vld_o;
    logic [9:0] y_g_o, cb_b_o, cr_r_o;
    logic [CNT_W-1:0] active_cnt_o;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    hd_fmt_if link ();
    hd_fmt_source i_hd_fmt_source (.sys_clk_i, .srst_i, .ten_bit_i, .rgb_mode_i, .family_i,
        .y_g_i, .cb_b_i, .cr_r_i, .sample_req_o, .link(link));
    hd_fmt_sink i_hd_fmt_sink (.sys_clk_i, .srst_i, .link(link), .y_g_o, .cb_b_o, .cr_r_o,
        .sample_vld_o, .chroma_vld_o, .active_cnt_o);
    hd_fmt_monitor i_hd_fmt_monitor (.sys_clk_i, .srst_i, .data(link.data), .valid(link.valid),
        .active(link.active), .rgb(link.rgb), .ten_bit(link.ten_bit), .line_start(link.line_start));
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    // A hang costs one count and ends the run
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            final_report();
        end
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    function automatic logic [9:0] exp_code(input int v, input bit c, input bit ten);
        int d, r, hi;
        d = ten ? 4 : 1;
        r = c ? (v * 224 * d + 128 * d * 65536 + 32768) >>> 16 : (v * 219 * d + 16 * d * 65536 + 32768) >>> 16;
        hi = ten ? 1019 : 254;
        r = r < d ? d : (r > hi ? hi : r);
        return ten ? 10'(r) : 10'(r << 2);
    endfunction : exp_code
    task automatic do_reset(input bit ten, input bit rgb, input family_t fam);
        @(posedge sys_clk_i);
        #1;
        srst_i = 1'b1;
        ten_bit_i = ten;
        rgb_mode_i = rgb;
        family_i = fam;
        repeat (8) @(posedge sys_clk_i);
        #1;
        srst_i = 1'b0;
    endtask : do_reset
    // Inputs stay constant, so any sample after the sixth pair shows them
    task automatic run_case(input string name, input int y, input int cb, input int cr);
        int n, k;
        bit c;
        @(posedge sys_clk_i);
        #1;
        y_g_i = 17'(y);
        cb_b_i = 17'(cb);
        cr_r_i = 17'(cr);
        c = !rgb_mode_i;
        n = 0;
        k = 0;
        while (k < 6 && n < 5000)
        begin
            @(posedge sys_clk_i);
            #1;
            n++;
            if (chroma_vld_o === 1'b1) k++;
        end
        `CHK("pairs", 1'b1, k == 6)
        `CHK("y_g", exp_code(y, 1'b0, ten_bit_i), y_g_o)
        `CHK("cb_b", exp_code(cb, c, ten_bit_i), cb_b_o)
        `CHK("cr_r", exp_code(cr, c, ten_bit_i), cr_r_o)
        `CHK("lsb", 2'b00, ten_bit_i ? 2'b00 : y_g_o[1:0])
        $display("test %s done", name);
    endtask : run_case
    task automatic check_line(input family_t fam, input int total);
        int n, a, r, f;
        do_reset(1'b1, 1'b0, fam);
        n = 0;
        a = 0;
        r = 0;
        f = 0;
        while (link.line_start !== 1'b1 && n < 5000)
        begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        n = 0;
        do
        begin
            @(posedge sys_clk_i);
            #1;
            n++;
            // Link shows a word two clocks after its sampling instant
            if (link.active === 1'b1 && a == 0) f = n;
            a += (link.active === 1'b1);
            r += (sample_req_o === 1'b1);
        end while (link.line_start !== 1'b1 && n < 5000);
        `CHK("total", total, n)
        `CHK("active", 1920, a)
        `CHK("requests", 1920, r)
        `CHK("first_active", SYNC_TO_ACTIVE + 2, f)
        `CHK("active_cnt", 12'd1920, active_cnt_o)
        $display("test line %0d done", total);
    endtask : check_line
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    initial
    begin
        do_reset(1'b1, 1'b0, FAM_60);
        run_case("black", 0, 0, -32768);
        run_case("peak", 65536, 32768, 0);
        run_case("clip", 131071, -65536, 65535);
        do_reset(1'b0, 1'b0, FAM_60);
        run_case("eight", 32768, -20000, 20000);
        do_reset(1'b1, 1'b1, FAM_60);
        run_case("rgb", 65536, 0, 32768);
        check_line(FAM_50, 2640);
        check_line(FAM_24, 2750);
        final_report();
    end
endmodule : hd_component_sample_formatter_tb
`default_nettype wire
